/* verilog/dcp_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - event enable/status cleared at reset, not sticky
// RULE2 - no EEPROM: power data and scale read zero
// RULE3 - endpoint L0s latency bits 8:6 read zero
// RULE4 - endpoint L1 latency bits 11:9 read zero
// RULE5 - bit 12 button present, default one
// RULE6 - bit 13 attention indicator present, default one
// RULE7 - bit 14 power indicator present, default one
// RULE8 - presence and power fields valid forward-transparent only
// RULE9 - eight-bit slot power value in 25:18
// RULE10 - slot power scale code in 27:26
// RULE11 - software multiplies value by scale factor
// RULE12 - event enable gates event generation
// RULE13 - event status reads one while event pending
// RULE14 - data select chooses presented power data
// RULE15 - slot power fields set by link message
// RULE16 - software writes to capability fields ignored
module dcp_top (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // configuration access
  input  wire dcp_pkg::dcp_cfg_req_t cfg_req,
  output logic               [31:0] cfg_rdata,
  output logic                      cfg_rvalid,
  // serial eeprom initialization
  input  wire logic                 eep_present,
  input  wire dcp_pkg::dcp_eep_wr_t eep_wr,
  // upstream link and mode
  input  wire dcp_pkg::dcp_spl_msg_t spl_msg,
  input  wire dcp_pkg::dcp_mode_t   mode,
  // power management events and capability valid
  input  wire logic                 pme_req,
  output logic                      pme_out,
  output logic                      cap_valid
);

  typedef struct packed {
    logic        attn_btn;
    logic        attn_ind;
    logic        pwr_ind;
    logic [7:0]  spl_value;
    logic [1:0]  spl_scale;
    logic [3:0]  data_sel;
    logic        sel_open;
    logic [31:0] rdata;
    logic        rvalid;
    logic        pme_out;
    logic        cap_valid;
  } dcp_top_state_t;

  dcp_top_state_t s_q, s_d;

  logic       pme_en;
  logic       pme_stat;
  logic       pme_raw;
  logic [7:0] pm_data;
  logic [1:0] pm_scale;
  logic       eep_pm;
  logic       eep_cap;
  logic       sw_pm;
  logic       rd_cap;
  logic       rd_pm;

  assign eep_pm  = eep_wr.wr && eep_wr.addr == dcp_pkg::PM_CSR_OFFSET;
  assign eep_cap = eep_wr.wr && eep_wr.addr == dcp_pkg::DEV_CAP_OFFSET;
  assign sw_pm   = cfg_req.wr && cfg_req.addr == dcp_pkg::PM_CSR_OFFSET;
  assign rd_cap  = cfg_req.rd && cfg_req.addr == dcp_pkg::DEV_CAP_OFFSET;
  assign rd_pm   = cfg_req.rd && cfg_req.addr == dcp_pkg::PM_CSR_OFFSET;

  dcp_pme u_pme (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .en_wr    (sw_pm),
    .en_wdata (cfg_req.wdata[dcp_pkg::PME_EN_BIT]),
    .stat_clr (sw_pm && cfg_req.wdata[dcp_pkg::PME_STAT_BIT]),
    .pme_req  (pme_req),
    .pme_en   (pme_en),
    .pme_stat (pme_stat),
    .pme_out  (pme_raw)
  );

  dcp_pm_data u_pm_data (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .eep_present (eep_present),
    .load        (eep_pm),
    .load_sel    (eep_wr.wdata[dcp_pkg::DATA_SEL_LSB +: 4]),
    .load_data   (eep_wr.wdata[dcp_pkg::PM_DATA_LSB +: 8]),
    .load_scale  (eep_wr.wdata[dcp_pkg::DATA_SCALE_LSB +: 2]),
    .sel         (s_q.data_sel),
    .rd_data     (pm_data),
    .rd_scale    (pm_scale)
  );

  function automatic logic [31:0] cap_word(input dcp_top_state_t s);
    logic [31:0] w;
    w = '0;
    w[dcp_pkg::L0S_LAT_LSB +: 3]   = dcp_pkg::EP_LAT_DISABLED; // [RULE3]
    w[dcp_pkg::L1_LAT_LSB +: 3]    = dcp_pkg::EP_LAT_DISABLED; // [RULE4]
    w[dcp_pkg::ATTN_BTN_BIT]       = s.attn_btn; // [RULE5]
    w[dcp_pkg::ATTN_IND_BIT]       = s.attn_ind; // [RULE6]
    w[dcp_pkg::PWR_IND_BIT]        = s.pwr_ind; // [RULE7]
    w[dcp_pkg::SPL_VALUE_LSB +: 8] = s.spl_value; // [RULE9]
    w[dcp_pkg::SPL_SCALE_LSB +: 2] = s.spl_scale; // [RULE10]
    cap_word = w;
  endfunction

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = cfg_req.rd;
    s_d.rdata  = '0;
    // eeprom alone may clear the presence bits
    if (eep_cap) begin // [RULE5] [RULE6] [RULE7] [RULE16]
      s_d.attn_btn = eep_wr.wdata[dcp_pkg::ATTN_BTN_BIT];
      s_d.attn_ind = eep_wr.wdata[dcp_pkg::ATTN_IND_BIT];
      s_d.pwr_ind  = eep_wr.wdata[dcp_pkg::PWR_IND_BIT];
    end
    if (spl_msg.valid) begin // [RULE15]
      s_d.spl_value = spl_msg.value;
      s_d.spl_scale = spl_msg.scale;
    end
    // data select: eeprom first, then software once opened
    if (eep_pm) begin // [RULE14]
      s_d.data_sel = eep_wr.wdata[dcp_pkg::DATA_SEL_LSB +: 4];
      s_d.sel_open = 1'b1;
    end else if (sw_pm && s_q.sel_open) begin
      s_d.data_sel = cfg_req.wdata[dcp_pkg::DATA_SEL_LSB +: 4];
    end
    if (cfg_req.rd) begin
      if (cfg_req.addr == dcp_pkg::DEV_CAP_OFFSET) begin
        s_d.rdata = cap_word(s_q);
      end else if (cfg_req.addr == dcp_pkg::PM_CSR_OFFSET) begin
        s_d.rdata[dcp_pkg::PME_EN_BIT]          = pme_en;
        s_d.rdata[dcp_pkg::DATA_SEL_LSB +: 4]   = s_q.data_sel;
        s_d.rdata[dcp_pkg::DATA_SCALE_LSB +: 2] = pm_scale; // [RULE2]
        s_d.rdata[dcp_pkg::PME_STAT_BIT]        = pme_stat; // [RULE13]
        s_d.rdata[dcp_pkg::PM_DATA_LSB +: 8]    = pm_data;
      end
    end
    s_d.pme_out   = pme_raw;
    s_d.cap_valid = (mode == dcp_pkg::DCP_MODE_FWD_TRANSPARENT); // [RULE8]
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.attn_btn  <= dcp_pkg::PRESENT_DEFAULT;
      s_q.attn_ind  <= dcp_pkg::PRESENT_DEFAULT;
      s_q.pwr_ind   <= dcp_pkg::PRESENT_DEFAULT;
      s_q.spl_value <= dcp_pkg::SPL_VALUE_RESET;
      s_q.spl_scale <= dcp_pkg::SPL_SCALE_RESET;
      s_q.data_sel  <= dcp_pkg::DATA_SEL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata  = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign pme_out    = s_q.pme_out;
  assign cap_valid  = s_q.cap_valid;

  property p_lat_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == dcp_pkg::DEV_CAP_OFFSET)
        |=> cfg_rvalid && cfg_rdata[11:6] == 6'h00;
  endproperty
  a_lat_zero: assert property (p_lat_zero) // [RULE3] [RULE4]
    else $error("endpoint latency fields not zero");

  property p_present_default;
    @(posedge sys_clk)
      !rst_n |=> (s_q.attn_btn && s_q.attn_ind && s_q.pwr_ind);
  endproperty
  a_present_default: assert property (p_present_default) // [RULE5]
    else $error("presence bits not one after reset");

  property p_sw_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      !eep_cap |=> $stable({s_q.attn_btn, s_q.attn_ind, s_q.pwr_ind});
  endproperty
  a_sw_ignored: assert property (p_sw_ignored) // [RULE16]
    else $error("presence bits changed without eeprom");

  property p_spl_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      spl_msg.valid |=> (s_q.spl_value == $past(spl_msg.value)
                         && s_q.spl_scale == $past(spl_msg.scale));
  endproperty
  a_spl_capture: assert property (p_spl_capture) // [RULE15] [RULE9]
    else $error("slot power limit not captured");

  property p_spl_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !spl_msg.valid |=> $stable({s_q.spl_value, s_q.spl_scale});
  endproperty
  a_spl_hold: assert property (p_spl_hold) // [RULE10]
    else $error("slot power limit changed without message");

  property p_mode_valid;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode != dcp_pkg::DCP_MODE_FWD_TRANSPARENT) |=> !cap_valid;
  endproperty
  a_mode_valid: assert property (p_mode_valid) // [RULE8]
    else $error("capability valid outside forward mode");

  property p_pm_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == dcp_pkg::PM_CSR_OFFSET && !eep_present)
        |=> cfg_rdata[31:24] == 8'h00 && cfg_rdata[14:13] == 2'h0;
  endproperty
  a_pm_zero: assert property (p_pm_zero) // [RULE2] [RULE14]
    else $error("power data read nonzero without eeprom");

  property p_btn_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_cap |=> cfg_rdata[dcp_pkg::ATTN_BTN_BIT] == $past(s_q.attn_btn);
  endproperty
  a_btn_read: assert property (p_btn_read) // [RULE5]
    else $error("button presence bit misread");

  property p_ind_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_cap |=> cfg_rdata[dcp_pkg::ATTN_IND_BIT] == $past(s_q.attn_ind);
  endproperty
  a_ind_read: assert property (p_ind_read) // [RULE6]
    else $error("attention indicator bit misread");

  property p_pwr_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_cap |=> cfg_rdata[dcp_pkg::PWR_IND_BIT] == $past(s_q.pwr_ind);
  endproperty
  a_pwr_read: assert property (p_pwr_read) // [RULE7]
    else $error("power indicator bit misread");

  property p_eep_presence;
    @(posedge sys_clk) disable iff (!rst_n)
      eep_cap |=> {s_q.pwr_ind, s_q.attn_ind, s_q.attn_btn}
                  == $past(eep_wr.wdata[14:12]);
  endproperty
  a_eep_presence: assert property (p_eep_presence) // [RULE6]
    else $error("eeprom presence load lost");

  property p_value_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_cap |=> cfg_rdata[25:18] == $past(s_q.spl_value);
  endproperty
  a_value_read: assert property (p_value_read) // [RULE9]
    else $error("slot power value misread");

  property p_scale_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_cap |=> cfg_rdata[27:26] == $past(s_q.spl_scale);
  endproperty
  a_scale_read: assert property (p_scale_read) // [RULE10]
    else $error("slot power scale misread");

  property p_en_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_pm |=> cfg_rdata[dcp_pkg::PME_EN_BIT] == $past(pme_en);
  endproperty
  a_en_read: assert property (p_en_read) // [RULE12]
    else $error("event enable misread");

  property p_stat_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_pm |=> cfg_rdata[dcp_pkg::PME_STAT_BIT] == $past(pme_stat);
  endproperty
  a_stat_read: assert property (p_stat_read) // [RULE13]
    else $error("event status misread");

  property p_sel_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_pm |=> cfg_rdata[12:9] == $past(s_q.data_sel);
  endproperty
  a_sel_read: assert property (p_sel_read) // [RULE14]
    else $error("data select misread");

  // select moves only on an eeprom load or an opened software write
  property p_sel_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      !eep_pm && !(sw_pm && s_q.sel_open) |=> $stable(s_q.data_sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked) // [RULE14]
    else $error("data select changed while locked");

  property p_pme_on;
    @(posedge sys_clk) disable iff (!rst_n)
      (pme_stat && pme_en) |=> pme_out;
  endproperty
  a_pme_on: assert property (p_pme_on) // [RULE12]
    else $error("event output missing");

  property p_pme_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !pme_en |=> !pme_out;
  endproperty
  a_pme_off: assert property (p_pme_off) // [RULE12]
    else $error("event output while disabled");

  property p_cap_valid_fwd;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == dcp_pkg::DCP_MODE_FWD_TRANSPARENT) |=> cap_valid;
  endproperty
  a_cap_valid_fwd: assert property (p_cap_valid_fwd) // [RULE8]
    else $error("capability not valid in forward mode");

  property p_reset_outputs;
    @(posedge sys_clk)
      !rst_n |=> !cfg_rvalid && !pme_out && !cap_valid
                 && cfg_rdata == 32'h0;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) // [RULE1]
    else $error("outputs not cleared by reset");

endmodule

/* verilog/dcp_pkg.sv */
package dcp_pkg;

  // configuration word offsets
  localparam logic [7:0] PM_CSR_OFFSET  = 8'h44;
  localparam logic [7:0] DEV_CAP_OFFSET = 8'h6c;

  // device capability field positions
  localparam int L0S_LAT_LSB   = 6;
  localparam int L1_LAT_LSB    = 9;
  localparam int ATTN_BTN_BIT  = 12;
  localparam int ATTN_IND_BIT  = 13;
  localparam int PWR_IND_BIT   = 14;
  localparam int SPL_VALUE_LSB = 18;
  localparam int SPL_SCALE_LSB = 26;

  // power management control/status field positions
  localparam int PME_EN_BIT     = 8;
  localparam int DATA_SEL_LSB   = 9;
  localparam int DATA_SCALE_LSB = 13;
  localparam int PME_STAT_BIT   = 15;
  localparam int PM_DATA_LSB    = 24;

  // values after reset
  localparam logic [2:0] EP_LAT_DISABLED  = 3'h0;
  localparam logic       PRESENT_DEFAULT  = 1'b1;
  localparam logic [7:0] SPL_VALUE_RESET  = 8'h00;
  localparam logic [1:0] SPL_SCALE_RESET  = 2'h0;
  localparam logic [3:0] DATA_SEL_RESET   = 4'h0;
  localparam logic [7:0] PM_DATA_NONE     = 8'h00;
  localparam logic [1:0] PM_SCALE_NONE    = 2'h0;

  // slot power limit scale codes
  localparam logic [1:0] SCALE_X1    = 2'h0;
  localparam logic [1:0] SCALE_X0P1  = 2'h1;
  localparam logic [1:0] SCALE_X0P01 = 2'h2;
  localparam logic [1:0] SCALE_X0P001 = 2'h3;

  // bridge operating modes
  typedef enum logic [1:0] {
    DCP_MODE_FWD_TRANSPARENT = 2'h0,
    DCP_MODE_REV_TRANSPARENT = 2'h1,
    DCP_MODE_NON_TRANSPARENT = 2'h3
  } dcp_mode_t;

  // configuration access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dcp_cfg_req_t;

  // serial EEPROM initialization write
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dcp_eep_wr_t;

  // slot power limit message from the upstream link
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } dcp_spl_msg_t;

endpackage

/* verilog/dcp_pm_data.sv */
`timescale 1ns/100ps
// four internal power data/scale slots, selected by the data select field
module dcp_pm_data (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // eeprom load
  input  wire logic       eep_present,
  input  wire logic       load,
  input  wire logic [3:0] load_sel,
  input  wire logic [7:0] load_data,
  input  wire logic [1:0] load_scale,
  // read side
  input  wire logic [3:0] sel,
  output logic      [7:0] rd_data,
  output logic      [1:0] rd_scale
);

  typedef struct packed {
    logic [3:0][7:0] data;
    logic [3:0][1:0] scale;
  } dcp_pmd_state_t;

  dcp_pmd_state_t s_q, s_d;

  // selects 0, 3, 4 and 7 map to slots 0..3; others have no slot
  function automatic logic [2:0] slot_of(input logic [3:0] k);
    case (k)
      4'h0:    slot_of = 3'h4;
      4'h3:    slot_of = 3'h5;
      4'h4:    slot_of = 3'h6;
      4'h7:    slot_of = 3'h7;
      default: slot_of = 3'h0;
    endcase
  endfunction

  logic [2:0] rd_slot;
  logic [2:0] ld_slot;

  always_comb begin
    ld_slot = slot_of(load_sel);
    s_d     = s_q;
    if (load && ld_slot[2]) begin
      s_d.data[ld_slot[1:0]]  = load_data;
      s_d.scale[ld_slot[1:0]] = load_scale;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    rd_slot  = slot_of(sel);
    rd_data  = dcp_pkg::PM_DATA_NONE;
    rd_scale = dcp_pkg::PM_SCALE_NONE;
    if (eep_present && rd_slot[2]) begin // [RULE2] [RULE14]
      rd_data  = s_q.data[rd_slot[1:0]];
      rd_scale = s_q.scale[rd_slot[1:0]];
    end
  end

  property p_no_eep_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      !eep_present |-> (rd_data == 8'h00 && rd_scale == 2'h0);
  endproperty
  a_no_eep_zero: assert property (p_no_eep_zero) // [RULE2]
    else $error("power data not zero without eeprom");

endmodule

/* verilog/dcp_pme.sv */
`timescale 1ns/100ps
// power management event enable and status
module dcp_pme (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // software control
  input  wire logic en_wr,
  input  wire logic en_wdata,
  input  wire logic stat_clr,
  // event source
  input  wire logic pme_req,
  // state
  output logic      pme_en,
  output logic      pme_stat,
  output logic      pme_out
);

  typedef struct packed {
    logic en;
    logic stat;
  } dcp_pme_state_t;

  dcp_pme_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (en_wr) begin
      s_d.en = en_wdata;
    end
    if (stat_clr) begin
      s_d.stat = 1'b0;
    end
    if (pme_req && s_q.en) begin // [RULE12] [RULE13]
      s_d.stat = 1'b1;
    end
  end

  // not sticky: ordinary reset clears both
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0; // [RULE1]
    end else begin
      s_q <= s_d;
    end
  end

  assign pme_en   = s_q.en;
  assign pme_stat = s_q.stat;
  assign pme_out  = s_q.stat && s_q.en;

  property p_reset_clear;
    @(posedge sys_clk) !rst_n |=> (!pme_en && !pme_stat);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RULE1]
    else $error("pme bits not cleared by reset");

  property p_blocked;
    @(posedge sys_clk) disable iff (!rst_n)
      (!pme_en && !en_wr && !pme_stat) |=> !pme_stat;
  endproperty
  a_blocked: assert property (p_blocked) // [RULE12]
    else $error("pme status set while disabled");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      (pme_req && pme_en) |=> pme_stat;
  endproperty
  a_set_wins: assert property (p_set_wins) // [RULE13]
    else $error("pme event lost");

endmodule

/* bench/dcp_top_bench.sv */
`timescale 1ns/100ps
module dcp_top_bench;
  localparam logic [31:0] CAP_M = 32'h0ffc_7fc0;
  localparam logic [31:0] PM_M  = 32'hff00_ff00;

  logic                  sys_clk;
  logic                  rst_n;
  dcp_pkg::dcp_cfg_req_t cfg_req;
  logic           [31:0] cfg_rdata;
  logic                  cfg_rvalid;
  logic                  eep_present;
  dcp_pkg::dcp_eep_wr_t  eep_wr;
  dcp_pkg::dcp_spl_msg_t spl_msg;
  dcp_pkg::dcp_mode_t    mode;
  logic                  pme_req;
  logic                  pme_out;
  logic                  cap_valid;
  int                    err_total;
  int                    check_count;
  logic            [2:0] pres;
  logic            [7:0] spl_v;
  logic            [1:0] spl_s;
  logic                  en_m;
  logic                  st_m;
  logic            [3:0] sel_m;
  logic            [9:0] slot [4];
  logic           [31:0] w;
  int                    k;
  int                    p;
  int                    ceil_e;
  logic           [31:0] rd_q;

  dcp_top uut (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .cfg_req     (cfg_req),
    .cfg_rdata   (cfg_rdata),
    .cfg_rvalid  (cfg_rvalid),
    .eep_present (eep_present),
    .eep_wr      (eep_wr),
    .spl_msg     (spl_msg),
    .mode        (mode),
    .pme_req     (pme_req),
    .pme_out     (pme_out),
    .cap_valid   (cap_valid)
  );

  always #20 sys_clk = ~sys_clk;

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // data slots exist only for selects 0, 3, 4 and 7
  function automatic int slot_of(logic [3:0] s);
    return (s == 4'h0) ? 0 : (s == 4'h3) ? 1 : (s == 4'h4) ? 2 :
           (s == 4'h7) ? 3 : -1;
  endfunction

  function automatic logic [31:0] exp_cap();
    logic [31:0] r;
    r = '0;
    r[14:12] = pres;
    r[25:18] = spl_v;
    r[27:26] = spl_s;
    return r;
  endfunction

  function automatic logic [31:0] exp_pm();
    logic [31:0] r;
    int          i;
    r = '0;
    i = slot_of(sel_m);
    r[8] = en_m;
    r[12:9] = sel_m;
    r[15] = st_m;
    if (eep_present && i >= 0) begin
      r[31:24] = slot[i][9:2];
      r[14:13] = slot[i][1:0];
    end
    return r;
  endfunction

  // ceiling in thousandths, worked out from the word as software reads it
  function automatic int sw_ceil(logic [31:0] r);
    int f;
    case (r[27:26])
      dcp_pkg::SCALE_X1:    f = 1000;
      dcp_pkg::SCALE_X0P1:  f = 100;
      dcp_pkg::SCALE_X0P01: f = 10;
      default:              f = 1;
    endcase
    return int'(r[25:18]) * f;
  endfunction

  task automatic cfg_rd(logic [7:0] a, logic [31:0] exp, logic [31:0] m);
    @(negedge sys_clk);
    cfg_req.rd = 1'b1;
    cfg_req.addr = a;
    @(negedge sys_clk);
    cfg_req.rd = 1'b0;
    check("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    check("cfg_rdata", exp & m, cfg_rdata & m);
    rd_q = cfg_rdata;
  endtask

  // one-cycle write from software or from the eeprom loader
  task automatic wr(bit eep, logic [7:0] a, logic [31:0] d);
    @(negedge sys_clk);
    if (eep) begin
      eep_wr.wr = 1'b1;
      eep_wr.addr = a;
      eep_wr.wdata = d;
    end else begin
      cfg_req.wr = 1'b1;
      cfg_req.addr = a;
      cfg_req.wdata = d;
    end
    @(negedge sys_clk);
    eep_wr.wr = 1'b0;
    cfg_req.wr = 1'b0;
  endtask

  task automatic spl_send(logic [7:0] v, logic [1:0] s);
    @(negedge sys_clk);
    spl_msg = '{valid: 1'b1, value: v, scale: s};
    @(negedge sys_clk);
    spl_msg.valid = 1'b0;
  endtask

  task automatic req_pulse();
    @(negedge sys_clk);
    pme_req = 1'b1;
    @(negedge sys_clk);
    pme_req = 1'b0;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    pres = 3'h7;
    spl_v = 8'h00;
    spl_s = 2'h0;
    en_m = 1'b0;
    st_m = 1'b0;
    sel_m = 4'h0;
  endtask

  initial begin
    sys_clk = 1'b0;
    cfg_req = '0;
    eep_wr = '0;
    spl_msg = '0;
    mode = dcp_pkg::DCP_MODE_FWD_TRANSPARENT;
    pme_req = 1'b0;
    eep_present = 1'b0;
    err_total = 0;
    check_count = 0;
    for (k = 0; k < 4; k++)
      slot[k] = '0;
    w = $urandom(61572);
    do_reset();
    cfg_rd(dcp_pkg::DEV_CAP_OFFSET, exp_cap(), CAP_M);
    cfg_rd(dcp_pkg::DEV_CAP_OFFSET, 32'h0000_7000, 32'h0000_7000);
    cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    cfg_rd(8'h50, 32'h0, 32'hffff_ffff);
    // validity follows the bridge mode
    for (k = 0; k < 3; k++) begin
      mode = (k == 0) ? dcp_pkg::DCP_MODE_REV_TRANSPARENT :
             (k == 1) ? dcp_pkg::DCP_MODE_NON_TRANSPARENT :
                        dcp_pkg::DCP_MODE_FWD_TRANSPARENT;
      repeat (2) @(negedge sys_clk);
      check("cap_valid", {31'h0, k == 2}, {31'h0, cap_valid});
    end
    // software writes ignored, link messages captured, all scale codes
    for (k = 0; k < 8; k++) begin
      wr(0, dcp_pkg::DEV_CAP_OFFSET, $urandom());
      spl_v = (k == 7) ? 8'hff : 8'($urandom());
      spl_s = k[1:0];
      spl_send(spl_v, spl_s);
      cfg_rd(dcp_pkg::DEV_CAP_OFFSET, exp_cap(), CAP_M);
      ceil_e = int'(spl_v) * 10 ** (3 - int'(spl_s));
      check("ceiling", ceil_e, sw_ceil(rd_q));
    end
    // eeprom overwrites the presence bits
    for (k = 0; k < 5; k++) begin
      w = $urandom();
      w[14:12] = (k == 0) ? 3'h0 : (k < 4) ? 3'(3'h7 ^ (3'h1 << (k - 1)))
                                            : w[14:12];
      wr(1, dcp_pkg::DEV_CAP_OFFSET, w);
      pres = w[14:12];
      cfg_rd(dcp_pkg::DEV_CAP_OFFSET, exp_cap(), CAP_M);
    end
    // event enable, status, clearing; select locked before eeprom load
    wr(0, dcp_pkg::PM_CSR_OFFSET, 32'h0000_0f00);
    en_m = 1'b1;
    req_pulse();
    st_m = 1'b1;
    cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    check("pme_out", 32'h1, {31'h0, pme_out});
    wr(0, dcp_pkg::PM_CSR_OFFSET, 32'h0000_8100);
    st_m = 1'b0;
    cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    wr(0, dcp_pkg::PM_CSR_OFFSET, 32'h0000_0000);
    en_m = 1'b0;
    req_pulse();
    cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    check("pme_out", 32'h0, {31'h0, pme_out});
    wr(0, dcp_pkg::PM_CSR_OFFSET, 32'h0000_0100);
    req_pulse();
    do_reset();
    cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    cfg_rd(dcp_pkg::DEV_CAP_OFFSET, exp_cap(), CAP_M);
    check("pme_out", 32'h0, {31'h0, pme_out});
    // eeprom loads the four data slots
    eep_present = 1'b1;
    for (k = 0; k < 4; k++) begin
      w = $urandom();
      w[12:9] = (k == 0) ? 4'h0 : (k == 1) ? 4'h3 : (k == 2) ? 4'h4 : 4'h7;
      w[8] = en_m;
      w[15] = 1'b0;
      wr(1, dcp_pkg::PM_CSR_OFFSET, w);
      slot[k] = {w[31:24], w[14:13]};
      sel_m = w[12:9];
      cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
    end
    // every select by software, with and without the eeprom fitted
    for (p = 1; p >= 0; p--) begin
      eep_present = p[0];
      for (k = 0; k < 16; k++) begin
        wr(0, dcp_pkg::PM_CSR_OFFSET, 32'(k) << 9);
        sel_m = k[3:0];
        cfg_rd(dcp_pkg::PM_CSR_OFFSET, exp_pm(), PM_M);
      end
    end
    tally_and_finish();
  end
endmodule
